// ===== hw/fvc_pkg.sv
// Package for the flow value converter: word kinds, gas selects,
// scale, offset, unit field layout and checksum constants.
// Assumes users refer to every item as fvc_pkg::name.
package fvc_pkg;

    localparam logic signed [15:0] FLOW_OFFSET  = -16'sd24576;
    localparam logic        [15:0] FLOW_SCALE   = 16'h00AA;
    localparam logic signed [15:0] TEMP_OFFSET  = 16'sh0000;
    localparam logic        [15:0] TEMP_SCALE   = 16'h00C8;

    localparam int UNIT_PREFIX_LSB = 0;
    localparam int UNIT_PREFIX_MSB = 3;
    localparam int UNIT_TBASE_LSB  = 4;
    localparam int UNIT_TBASE_MSB  = 7;
    localparam int UNIT_BASE_LSB   = 8;
    localparam int UNIT_BASE_MSB   = 12;

    localparam logic [4:0]  UNIT_STD_LITER = 5'h01;
    localparam logic [3:0]  TBASE_PER_MIN  = 4'h4;
    localparam logic [3:0]  PREFIX_ONE     = 4'h8;
    localparam logic [15:0] UNIT_SLM_WORD  = 16'h0148;

    localparam logic [7:0]  CRC_POLY = 8'h31;
    localparam logic [7:0]  CRC_INIT = 8'hFF;

    typedef enum logic [1:0]
    {
        KIND_FLOW = 2'b00,
        KIND_TEMP = 2'b01,
        KIND_UNIT = 2'b10
    } fvc_kind_t;

    typedef enum logic [2:0]
    {
        GAS_O2    = 3'b000,
        GAS_AIR   = 3'b001,
        GAS_HEOX  = 3'b010,
        GAS_MIX0  = 3'b011,
        GAS_MIX1  = 3'b100
    } fvc_gas_t;

    typedef struct packed
    {
        fvc_kind_t   kind;
        fvc_gas_t    gas;
        logic [15:0] word;
        logic [7:0]  crc;
    } fvc_in_t;

    typedef struct packed
    {
        fvc_kind_t          kind;
        logic               crc_ok;
        logic               cal_ok;
        logic signed [15:0] raw;
        logic signed [16:0] quot;
        logic        [15:0] rem;
        logic        [3:0]  prefix;
        logic        [3:0]  tbase;
        logic        [4:0]  unit;
        logic               unit_slm;
    } fvc_out_t;

endpackage : fvc_pkg

// ===== hw/fvc_top.sv
// Flow value converter: checks, scales and decodes sensor words.
// Assumes words arrive from a reader on clk with valid/ready, and the
// consumer takes results with valid/ready; a stall never drops a word.
//
// Contract
// - Flow word is 16-bit signed two's complement
// - Temperature signed, offset zero, scale 200
// - Flow is raw minus offset over 170
// - Helium entries only on helium variant
// - Unit word: prefix, time base, unit fields
// - Recognise standard liter per minute codes
// - Checksum poly 0x31, init 0xFF, no reflect
`timescale 1ns/1ps
`default_nettype none
module fvc_top #(
    parameter bit HELIUM_VARIANT = 1'b0
) (
    input  wire logic            clk,
    input  wire logic            rstn,
    input  wire fvc_pkg::fvc_in_t in_data,
    input  wire logic            in_valid,
    output logic                 in_ready,
    output fvc_pkg::fvc_out_t    out_data,
    output logic                 out_valid,
    input  wire logic            out_ready
);

    ////////////////////////////////////////////////////////////////////////
    // Checksum over the two data bytes
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = fvc_pkg::CRC_INIT;
        for (int i = 15; i >= 0; i--)
        begin
            if (c[7] ^ w[i])
                c = {c[6:0], 1'b0} ^ fvc_pkg::CRC_POLY;
            else
                c = {c[6:0], 1'b0};
        end
        return c;
    endfunction : crc8

    ////////////////////////////////////////////////////////////////////////
    // Conversion of one word, purely combinational
    fvc_pkg::fvc_out_t conv;
    logic signed [17:0] diff;
    logic        [15:0] scale;
    logic        [16:0] mag;
    logic        [16:0] q_mag;
    logic        [16:0] r_mag;
    logic               heox;

    always_comb
    begin
        conv        = '0;
        conv.kind   = in_data.kind;
        conv.crc_ok = (crc8(in_data.word) == in_data.crc);
        conv.raw    = $signed(in_data.word);
        heox = (in_data.gas == fvc_pkg::GAS_HEOX) ||
               (in_data.gas == fvc_pkg::GAS_MIX1);
        // Base variant lacks helium tables; flag, don't guess
        conv.cal_ok = (in_data.gas <= fvc_pkg::GAS_MIX1) &&
                      (!heox || HELIUM_VARIANT);
        if (in_data.kind == fvc_pkg::KIND_TEMP)
        begin
            diff  = 18'(conv.raw) - 18'(fvc_pkg::TEMP_OFFSET);
            scale = fvc_pkg::TEMP_SCALE;
        end
        else
        begin
            diff  = 18'(conv.raw) - 18'(fvc_pkg::FLOW_OFFSET);
            scale = fvc_pkg::FLOW_SCALE;
        end
        // Truncating division; remainder is the unsigned magnitude, quotient takes the sign
        mag   = diff[17] ? 17'(-diff) : diff[16:0];
        q_mag = mag / 17'(scale);
        r_mag = mag % 17'(scale);
        conv.quot = diff[17] ? -$signed(q_mag) : $signed(q_mag);
        conv.rem  = r_mag[15:0];
        if (in_data.kind == fvc_pkg::KIND_UNIT)
        begin
            conv.quot = '0;
            conv.rem  = '0;
        end
        // Bits 15:13 ignored by design
        conv.prefix = in_data.word[fvc_pkg::UNIT_PREFIX_MSB:
                                   fvc_pkg::UNIT_PREFIX_LSB];
        conv.tbase  = in_data.word[fvc_pkg::UNIT_TBASE_MSB:
                                   fvc_pkg::UNIT_TBASE_LSB];
        conv.unit   = in_data.word[fvc_pkg::UNIT_BASE_MSB:
                                   fvc_pkg::UNIT_BASE_LSB];
        conv.unit_slm = (conv.unit == fvc_pkg::UNIT_STD_LITER) &&
                        (conv.tbase == fvc_pkg::TBASE_PER_MIN) &&
                        (conv.prefix == fvc_pkg::PREFIX_ONE) &&
                        ({3'h0, in_data.word[12:0]} ==
                         fvc_pkg::UNIT_SLM_WORD);
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-entry buffer; flags are flops, so no comb path in to out
    fvc_pkg::fvc_out_t buf_ff [2];
    fvc_pkg::fvc_out_t nxt_buf [2];
    logic [1:0]        cnt_ff;
    logic [1:0]        nxt_cnt;
    logic              in_ready_ff;
    logic              nxt_in_ready;
    logic              out_valid_ff;
    logic              nxt_out_valid;
    logic              push;
    logic              pop;

    always_comb
    begin
        push    = in_valid && in_ready_ff;
        pop     = out_ready && out_valid_ff;
        nxt_buf = buf_ff;
        nxt_cnt = cnt_ff;
        case ({push, pop})
            2'b10:
            begin
                // Fill the first free slot
                if (cnt_ff == 2'h0)
                begin
                    nxt_buf[0] = conv;
                end
                else
                begin
                    nxt_buf[1] = conv;
                end
                nxt_cnt = cnt_ff + 2'h1;
            end
            2'b01:
            begin
                nxt_buf[0] = buf_ff[1];
                nxt_cnt    = cnt_ff - 2'h1;
            end
            2'b11:
            begin
                // Fill unchanged; with one held the new word becomes head, with two it goes behind
                if (cnt_ff == 2'h1)
                begin
                    nxt_buf[0] = conv;
                end
                else
                begin
                    nxt_buf[0] = buf_ff[1];
                    nxt_buf[1] = conv;
                end
            end
            default:
            begin
                nxt_cnt = cnt_ff;
            end
        endcase
        // Flags follow the next fill so they land with it
        nxt_in_ready  = (nxt_cnt != 2'h2);
        nxt_out_valid = (nxt_cnt != 2'h0);
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            buf_ff[0]    <= '0;
            buf_ff[1]    <= '0;
            cnt_ff       <= 2'h0;
            in_ready_ff  <= 1'b1;
            out_valid_ff <= 1'b0;
        end
        else
        begin
            buf_ff       <= nxt_buf;
            cnt_ff       <= nxt_cnt;
            in_ready_ff  <= nxt_in_ready;
            out_valid_ff <= nxt_out_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops
    always_comb
    begin
        in_ready  = in_ready_ff;
        out_valid = out_valid_ff;
        out_data  = buf_ff[0];
    end

endmodule : fvc_top
`default_nettype wire

// ===== testbench/fvc_props.sv
// Checker for fvc_top output entries.
// Assumes binding to fvc_top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module fvc_props #(
    parameter bit HELIUM_VARIANT = 1'b0
) (
    input wire logic              clk,
    input wire logic              rstn,
    input wire fvc_pkg::fvc_in_t  in_data,
    input wire logic              in_valid,
    input wire logic              in_ready,
    input wire fvc_pkg::fvc_out_t out_data,
    input wire logic              out_valid,
    input wire logic              out_ready
);
default clocking @(posedge clk); endclocking
default disable iff (!rstn);
wire fl = out_valid && out_data.kind == fvc_pkg::KIND_FLOW;
wire tp = out_valid && out_data.kind == fvc_pkg::KIND_TEMP;
wire un = out_valid && out_data.kind == fvc_pkg::KIND_UNIT;
////////////////
a_flow_rem: assert property (fl |-> out_data.rem < 16'h00AA)
    else $error("flow rem");
a_temp_rem: assert property (tp |-> out_data.rem < 16'h00C8)
    else $error("temp rem");
a_flow_min: assert property (fl && out_data.raw == 16'sh8000
    |-> out_data.quot == -17'sd48) else $error("flow min");
a_unit_fields: assert property (out_valid
    |-> {out_data.unit, out_data.tbase, out_data.prefix}
        == out_data.raw[12:0]) else $error("fields");
a_slm_code: assert property (out_valid
    |-> out_data.unit_slm == (out_data.raw[12:0] == 13'h0148))
    else $error("slm");
a_unit_zero: assert property (un |-> !out_data.quot && !out_data.rem)
    else $error("unit quot");
a_out_hold: assert property (out_valid && !out_ready
    |=> out_valid && $stable(out_data)) else $error("hold");
a_cal_gas: assert property (in_valid && in_ready && !out_valid
    && in_data.gas == fvc_pkg::GAS_HEOX
    |=> out_data.cal_ok == HELIUM_VARIANT) else $error("cal");
endmodule : fvc_props
bind fvc_top fvc_props #(.HELIUM_VARIANT(HELIUM_VARIANT)) u_props (
    .clk(clk), .rstn(rstn), .in_data(in_data), .in_valid(in_valid),
    .in_ready(in_ready), .out_data(out_data), .out_valid(out_valid),
    .out_ready(out_ready));
`default_nettype wire

// ===== testbench/fvc_reader.sv
// Reader model: hands checked words to fvc_top.
// Assumes the bench calls send and idle.
`timescale 1ns/1ps
`default_nettype none
module fvc_reader (
    input  wire logic        clk,
    input  wire logic        in_ready,
    output fvc_pkg::fvc_in_t in_data,
    output logic             in_valid
);
int hung = 0;
initial in_valid = 1'b0;
initial in_data = '0;
function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--)
        c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
    return c;
endfunction : crc8
// Crc field of x is an error mask, zero for a good word
task automatic send(input fvc_pkg::fvc_in_t x);
    int n;
    n = 0;
    in_data <= {x.kind, x.gas, x.word, crc8(x.word) ^ x.crc};
    in_valid <= 1'b1;
    do @(posedge clk); while (!in_ready && ++n < 64);
    hung += n / 64;
endtask : send
// Released data is scrambled, never left looking valid
task automatic idle;
    in_valid <= 1'b0;
    in_data <= ~in_data;
    @(posedge clk);
endtask : idle
endmodule : fvc_reader
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench for fvc_top.
// Assumes fvc_reader and fvc_props compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module tb;
logic clk, rstn, out_ready, in_ready, out_valid, in_valid;
fvc_pkg::fvc_in_t in_data, e, q[$];
fvc_pkg::fvc_out_t out_data;
int mismatches, n_compared, d, s;
fvc_pkg::fvc_in_t rows[10] = '{{2'h0, 3'h2, 16'hA001, 8'h00},
    {2'h0, 3'h0, 16'hA000, 8'h00}, {2'h0, 3'h1, 16'h7FFF, 8'h00},
    {2'h0, 3'h3, 16'h8000, 8'h00}, {2'h1, 3'h4, 16'hFF37, 8'h00},
    {2'h1, 3'h0, 16'h0190, 8'h00}, {2'h2, 3'h0, 16'h0148, 8'h00},
    {2'h2, 3'h1, 16'hE148, 8'h00}, {2'h2, 3'h5, 16'h0149, 8'h00},
    {2'h0, 3'h1, 16'hBEEF, 8'h01}};
fvc_top DUT (.clk(clk), .rstn(rstn), .in_data(in_data),
    .in_valid(in_valid), .in_ready(in_ready), .out_data(out_data),
    .out_valid(out_valid), .out_ready(out_ready));
fvc_reader u_rd (.clk(clk), .in_ready(in_ready), .in_data(in_data),
    .in_valid(in_valid));
initial
begin
    clk = 1'b0;
    forever #5 clk = ~clk;
end
task automatic chk(string n, logic [31:0] g, logic [31:0] x);
    n_compared++;
    if (g !== x)
    begin
        mismatches++;
        $display("BAD %s exp %h got %h", n, x, g);
    end
endtask : chk
task report_and_stop;
    $display("checks %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask : report_and_stop
////////////////
always @(posedge clk)
    if (rstn && in_valid && in_ready)
        q.push_back(in_data);
always @(posedge clk)
    if (rstn && out_valid && out_ready)
    begin
        e = q.pop_front();
        s = e.kind == fvc_pkg::KIND_TEMP ? 200 : 170;
        d = $signed(e.word) + (e.kind == fvc_pkg::KIND_TEMP ? 0 : 24576);
        d = e.kind == fvc_pkg::KIND_UNIT ? 0 : d;
        chk("quot", out_data.quot, d / s);
        chk("rem", out_data.rem, (d < 0 ? -d : d) % s);
        chk("fields", {out_data.unit, out_data.tbase, out_data.prefix},
            e.word[12:0]);
        chk("slm", out_data.unit_slm, e.word[12:0] == 13'h0148);
        chk("crc", out_data.crc_ok, e.crc == u_rd.crc8(e.word));
        chk("cal", out_data.cal_ok, e.gas inside {0, 1, 3});
    end
////////////////
initial
begin
    rstn = 1'b0;
    out_ready = 1'b1;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    foreach (rows[i]) u_rd.send(rows[i]);
    u_rd.idle();
    // Stall with two held, third must wait
    out_ready <= 1'b0;
    u_rd.send(rows[3]);
    u_rd.send(rows[4]);
    u_rd.idle();
    chk("full", in_ready, 0);
    // Third word waits until the consumer frees a slot
    fork
        u_rd.send(rows[5]);
        begin
            repeat (3) @(posedge clk);
            out_ready <= 1'b1;
        end
    join
    u_rd.idle();
    for (int k = 0; k < 50 && q.size(); k++) @(posedge clk);
    chk("left", q.size(), 0);
    // Reset with a word held
    out_ready <= 1'b0;
    u_rd.send(rows[6]);
    u_rd.idle();
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    q.delete();
    @(posedge clk);
    chk("rst", {out_valid, in_ready}, 1);
    chk("hang", u_rd.hung, 0);
    report_and_stop();
end
endmodule : tb
`default_nettype wire
